// ### rtl/pmnr_top.sv
// Power-management NMI cause flags, input status and suspend readback registers.
// Assumes the enable register, port and interrupt-controller state live elsewhere
// and arrive here as synchronous levels; the CPU reaches registers as 16-bit I/O ports.

// Functional notes
// - Set a cause flag for each input 7..2 whose enabled change raised NMI.
// - Cause flag and latched status clear only when both its NMI and attention enables are cleared.
// - With both enables set, flag and status hold until both are cleared.
// - Cause register bits 15..8 and 1..0 read zero; software writes zero.
// - Inputs 2 through 6 flag on any rising or falling transition.
// - Serial readback bits 15..14 copy serial port A register 2 bits 7..6.
// - Serial readback bits 13..12 copy serial port B register 2 bits 7..6.
// - Serial readback bits 11..8 copy parallel register 2 bits 3..0.
// - Serial readback bits 7..0 copy parallel register 0 entirely.
// - Serial/parallel readback is read-only; writes change nothing.
// - Controller readback is read-only; writes change nothing.
// - Controller readback exposes write-only controller state for restore after resume.
// - Bit 15 shows the live activity timeout comparator output, test only.
// - Bits 14..13 return a fixed chip identity code.
// - Bits 12 and 11 return vector bit 7 of master and slave.
// - Bit 10 master special nested, bit 9 master automatic end of interrupt.
// - Bits 7..5 and 4..2 return master and slave lowest priority.
// - Bits 1 and 0 show master and slave special mask mode.
module pmnr_top #(
    parameter logic [1:0] CHIP_IDENTITY_FIELD = 2'h2,  // Arbitrary value
    parameter bit INPUT7_ACTIVE_HIGH = 1'b1
) (
    input wire logic clk_i,                                   // System clock, 25 MHz
    input wire logic nrst_i,                                  // Async reset, active low
    input wire logic [15:0] io_addr_i,                        // I/O port address
    input wire logic io_rd_i,                                 // Read strobe
    input wire logic io_wr_i,                                 // Write strobe
    input wire logic [15:0] io_wdata_i,                       // Write data
    output logic [15:0] io_rdata_o,                           // Read data, held
    input wire logic [7:0] pm_in_i,                           // Power-management inputs
    input wire logic [5:0] nmi_enable_bits_i,                 // NMI enables 7..2
    input wire logic [5:0] attention_enable_bits_i,           // Attention enables 7..2
    input wire pmnr_pkg::pmnr_port_shadow_type port_shadow_i, // Port register copies
    input wire pmnr_pkg::pmnr_pic_shadow_type pic_shadow_i,   // Controller state
    input wire logic activity_timeout_compare_i,              // Timeout comparator
    output logic [5:0] nmi_cause_flags_o,                     // Cause flags 7..2
    output logic [7:0] pm_sense_levels_o,                     // Input status 7..0
    output logic nmi_o                                        // NMI request
);

    // ==========================================================
    // Change detection
    logic [5:0] change;

    genvar gi;
    generate
        for (gi = 0; gi < pmnr_pkg::PM_FLAGS; gi++)
        begin : g_edge
            pmnr_edge_det #(
                .BOTH_EDGES((gi + pmnr_pkg::PM_FIRST_FLAG) != pmnr_pkg::ACTIVE_EDGE_INPUT),
                .ACTIVE_HIGH(INPUT7_ACTIVE_HIGH)
            ) u_edge (
                .clk_i(clk_i),
                .nrst_i(nrst_i),
                .level_i(pm_in_i[gi + pmnr_pkg::PM_FIRST_FLAG]),
                .event_o(change[gi])
            );
        end
    endgenerate

    // ==========================================================
    // State
    pmnr_pkg::pmnr_state_type state_q;
    pmnr_pkg::pmnr_state_type state_d;
    logic [5:0] latched;
    logic [5:0] level_set;
    logic [5:0] flag_set;
    logic [5:0] flag_clr;
    logic hit_cause;
    logic hit_port;
    logic hit_pic;
    logic [15:0] cause_word;
    logic [15:0] port_word;
    logic [15:0] pic_word;
    logic [15:0] rd_word;

    // ==========================================================
    // Set and clear terms
    always_comb
    begin
        // Either enable turns a status bit into a latched transition
        latched = nmi_enable_bits_i | attention_enable_bits_i;
        level_set = change & latched;
        flag_set = change & nmi_enable_bits_i;
        flag_clr = ~latched;
    end

    // ==========================================================
    // Address decode
    always_comb
    begin
        hit_cause = 1'b0;
        hit_port = 1'b0;
        hit_pic = 1'b0;
        // Full 16-bit compare; no aliases
        if (io_addr_i == pmnr_pkg::NMI_CAUSE_STATUS_ADDR)
        begin
            hit_cause = 1'b1;
        end
        else if (io_addr_i == pmnr_pkg::SERIAL_PARALLEL_READBACK_ADDR)
        begin
            hit_port = 1'b1;
        end
        else if (io_addr_i == pmnr_pkg::IRQ_CONTROLLER_READBACK_ADDR)
        begin
            hit_pic = 1'b1;
        end
    end

    // ==========================================================
    // Read words
    always_comb
    begin
        cause_word = 16'h0000;
        cause_word[pmnr_pkg::NMI_FLAG_LSB +: pmnr_pkg::PM_FLAGS] = state_q.nmi_cause_flags;

        // Shadow sources are taken live at the read edge
        port_word = 16'h0000;
        port_word[pmnr_pkg::SP_A_LSB +: 2] = port_shadow_i.serial_a_line_ctl_bits;
        port_word[pmnr_pkg::SP_B_LSB +: 2] = port_shadow_i.serial_b_line_ctl_bits;
        port_word[pmnr_pkg::PP2_LSB +: 4] = port_shadow_i.parallel_reg2_low_bits;
        port_word[pmnr_pkg::PP0_LSB +: 8] = port_shadow_i.parallel_reg0_copy;

        pic_word = 16'h0000;
        pic_word[pmnr_pkg::TIMEOUT_BIT] = activity_timeout_compare_i;
        pic_word[pmnr_pkg::CHIP_ID_LSB +: 2] = CHIP_IDENTITY_FIELD;
        pic_word[pmnr_pkg::MASTER_VEC_BIT] = pic_shadow_i.master_vector_msb;
        pic_word[pmnr_pkg::SLAVE_VEC_BIT] = pic_shadow_i.slave_vector_msb;
        pic_word[pmnr_pkg::NESTED_BIT] = pic_shadow_i.master_special_nested_state;
        pic_word[pmnr_pkg::AUTO_EOI_BIT] = pic_shadow_i.master_auto_eoi_state;
        pic_word[pmnr_pkg::ROTATE_EOI_BIT] = pic_shadow_i.master_rotate_eoi_state;
        pic_word[pmnr_pkg::MASTER_PRIO_LSB +: 3] = pic_shadow_i.master_lowest_priority;
        pic_word[pmnr_pkg::SLAVE_PRIO_LSB +: 3] = pic_shadow_i.slave_lowest_priority;
        pic_word[pmnr_pkg::MASTER_SMM_BIT] = pic_shadow_i.master_special_mask_state;
        pic_word[pmnr_pkg::SLAVE_SMM_BIT] = pic_shadow_i.slave_special_mask_state;
    end

    // ==========================================================
    // Read select
    always_comb
    begin
        if (hit_cause)
        begin
            rd_word = cause_word;
        end
        else if (hit_port)
        begin
            rd_word = port_word;
        end
        else if (hit_pic)
        begin
            rd_word = pic_word;
        end
        else
        begin
            rd_word = 16'h0000;
        end
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        state_d = state_q;
        // Inputs 1 and 0 always show live level
        state_d.pm_sense_levels[1:0] = pm_in_i[1:0];
        for (int i = 0; i < pmnr_pkg::PM_FLAGS; i++)
        begin
            if (flag_clr[i])
            begin
                state_d.nmi_cause_flags[i] = 1'b0;
                state_d.pm_sense_levels[i + pmnr_pkg::PM_FIRST_FLAG] = pm_in_i[i + pmnr_pkg::PM_FIRST_FLAG];
            end
            else
            begin
                if (level_set[i])
                begin
                    state_d.pm_sense_levels[i + pmnr_pkg::PM_FIRST_FLAG] = 1'b1;
                end
                if (flag_set[i])
                begin
                    state_d.nmi_cause_flags[i] = 1'b1;
                end
            end
        end
        // Request rises on the same edge as its flag
        state_d.nmi_req = |state_d.nmi_cause_flags;

        // Writes to all three ports are ignored; nothing here stores io_wdata_i
        if (io_rd_i)
        begin
            state_d.read_data = rd_word;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q.nmi_cause_flags <= pmnr_pkg::FLAGS_RESET;
            state_q.pm_sense_levels <= pmnr_pkg::LEVELS_RESET;
            state_q.nmi_req <= 1'b0;
            state_q.read_data <= pmnr_pkg::READ_DATA_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    assign io_rdata_o = state_q.read_data;
    assign nmi_cause_flags_o = state_q.nmi_cause_flags;
    assign pm_sense_levels_o = state_q.pm_sense_levels;
    assign nmi_o = state_q.nmi_req;

endmodule : pmnr_top

// ### rtl/pmnr_pkg.sv
// Shared constants and carriers for the power-management flag and readback block.
// Assumes a 16-bit I/O port space decoded in full by the block.
package pmnr_pkg;

    // ==========================================================
    // Port addresses
    localparam logic [15:0] NMI_CAUSE_STATUS_ADDR = 16'h9072;
    localparam logic [15:0] SERIAL_PARALLEL_READBACK_ADDR = 16'hd072;
    localparam logic [15:0] IRQ_CONTROLLER_READBACK_ADDR = 16'hd472;

    // ==========================================================
    // Field positions and widths
    localparam int PM_INPUTS = 8;
    localparam int PM_FIRST_FLAG = 2;
    localparam int PM_FLAGS = 6;
    localparam int ACTIVE_EDGE_INPUT = 7;
    localparam int NMI_FLAG_LSB = 2;
    localparam int SP_A_LSB = 14;
    localparam int SP_B_LSB = 12;
    localparam int PP2_LSB = 8;
    localparam int PP0_LSB = 0;
    localparam int TIMEOUT_BIT = 15;
    localparam int CHIP_ID_LSB = 13;
    localparam int MASTER_VEC_BIT = 12;
    localparam int SLAVE_VEC_BIT = 11;
    localparam int NESTED_BIT = 10;
    localparam int AUTO_EOI_BIT = 9;
    localparam int ROTATE_EOI_BIT = 8;
    localparam int MASTER_PRIO_LSB = 5;
    localparam int SLAVE_PRIO_LSB = 2;
    localparam int MASTER_SMM_BIT = 1;
    localparam int SLAVE_SMM_BIT = 0;

    // ==========================================================
    // Reset values
    localparam logic [15:0] READ_DATA_RESET = 16'h0000;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [7:0] LEVELS_RESET = 8'h00;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [1:0] serial_a_line_ctl_bits;
        logic [1:0] serial_b_line_ctl_bits;
        logic [3:0] parallel_reg2_low_bits;
        logic [7:0] parallel_reg0_copy;
    } pmnr_port_shadow_type;

    typedef struct packed {
        logic master_vector_msb;
        logic slave_vector_msb;
        logic master_special_nested_state;
        logic master_auto_eoi_state;
        logic master_rotate_eoi_state;
        logic [2:0] master_lowest_priority;
        logic [2:0] slave_lowest_priority;
        logic master_special_mask_state;
        logic slave_special_mask_state;
    } pmnr_pic_shadow_type;

    typedef struct packed {
        logic [5:0] nmi_cause_flags;
        logic [7:0] pm_sense_levels;
        logic nmi_req;
        logic [15:0] read_data;
    } pmnr_state_type;

endpackage : pmnr_pkg

// ### rtl/pmnr_edge_det.sv
// Change detector for one power-management input.
// Assumes the input is already synchronous to clk_i.
module pmnr_edge_det #(
    parameter bit BOTH_EDGES = 1'b1,
    parameter bit ACTIVE_HIGH = 1'b1
) (
    input wire logic clk_i,    // System clock
    input wire logic nrst_i,   // Async reset, active low
    input wire logic level_i,  // Input level
    output logic event_o       // Qualifying change this cycle
);

    logic prev_q;
    logic prev_d;

    always_comb
    begin
        prev_d = level_i;
        if (BOTH_EDGES)
        begin
            event_o = level_i ^ prev_q;
        end
        else
        begin
            event_o = (level_i == ACTIVE_HIGH) && (prev_q != ACTIVE_HIGH);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            prev_q <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
        end
    end

endmodule : pmnr_edge_det

// ### test/pmnr_top_properties.sv
// Port-level checker for the flag and readback block.
// Sees only top-level ports; attached by bind below.
module pmnr_top_properties #(
    parameter logic [1:0] CHIP_IDENTITY_FIELD = 2'h2  // Identity code
) (
    input wire logic clk_i,  // Clock
    input wire logic nrst_i,  // Reset, low
    input wire logic [15:0] io_addr_i,  // Address
    input wire logic io_rd_i,  // Read
    input wire logic [15:0] io_rdata_o,  // Read data
    input wire logic [7:0] pm_in_i,  // Inputs
    input wire logic [5:0] nmi_enable_bits_i,  // NMI enables
    input wire logic [5:0] attention_enable_bits_i,  // Attention enables
    input wire pmnr_pkg::pmnr_port_shadow_type port_shadow_i,  // Port copies
    input wire pmnr_pkg::pmnr_pic_shadow_type pic_shadow_i,  // Controller state
    input wire logic activity_timeout_compare_i,  // Comparator
    input wire logic [5:0] nmi_cause_flags_o,  // Cause flags
    input wire logic nmi_o  // NMI
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic [5:0] en_any;
    logic [15:0] a;
    assign en_any = nmi_enable_bits_i | attention_enable_bits_i;
    assign a = io_addr_i;
    // ==========================================
    // Read words
    chk_cause_read: assert property (io_rd_i && a == pmnr_pkg::NMI_CAUSE_STATUS_ADDR
        |=> io_rdata_o == {8'h00, $past(nmi_cause_flags_o), 2'b00}) else $error("cause word wrong");
    chk_serial_read: assert property (io_rd_i && a == pmnr_pkg::SERIAL_PARALLEL_READBACK_ADDR
        |=> io_rdata_o == $past(port_shadow_i)) else $error("serial word wrong");
    chk_pic_read: assert property (io_rd_i && a == pmnr_pkg::IRQ_CONTROLLER_READBACK_ADDR
        |=> io_rdata_o == {$past(activity_timeout_compare_i), CHIP_IDENTITY_FIELD, $past(pic_shadow_i)})
        else $error("controller word wrong");
    chk_unmapped_zero: assert property (io_rd_i && !(a inside {16'h9072, 16'hd072, 16'hd472})
        |=> io_rdata_o == 16'h0000) else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!io_rd_i |=> $stable(io_rdata_o)) else $error("read data moved");
    // ==========================================
    // Flags
    chk_flag_clear: assert property (1'b1 |=> (nmi_cause_flags_o & ~$past(en_any)) == 6'h00)
        else $error("flag kept without enable");
    chk_flag_keep: assert property (($past(nmi_cause_flags_o) & $past(en_any) & ~nmi_cause_flags_o) == 6'h00)
        else $error("flag lost while enabled");
    chk_flag_cause: assert property ($past(nrst_i, 2) |-> (nmi_cause_flags_o & ~$past(nmi_cause_flags_o)
        & ~($past(nmi_enable_bits_i) & ($past(pm_in_i[7:2]) ^ $past(pm_in_i[7:2], 2)))) == 6'h00)
        else $error("flag set without cause");
    chk_edge_seven: assert property ($past(nrst_i, 2) && $rose(nmi_cause_flags_o[5])
        |-> $past(pm_in_i[7]) && !$past(pm_in_i[7], 2)) else $error("input 7 wrong edge");
    chk_nmi_follow: assert property (nmi_o == (|nmi_cause_flags_o)) else $error("nmi wrong");
endmodule : pmnr_top_properties

bind pmnr_top pmnr_top_properties #(.CHIP_IDENTITY_FIELD(CHIP_IDENTITY_FIELD)) pmnr_top_properties_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o),
    .pm_in_i(pm_in_i), .nmi_enable_bits_i(nmi_enable_bits_i), .attention_enable_bits_i(attention_enable_bits_i),
    .port_shadow_i(port_shadow_i), .pic_shadow_i(pic_shadow_i),
    .activity_timeout_compare_i(activity_timeout_compare_i), .nmi_cause_flags_o(nmi_cause_flags_o), .nmi_o(nmi_o));

// ### test/pmnr_top_bench.sv
// Self-checking bench for the flag and readback block.
// Drives all inputs on the falling edge of a 25 MHz clock.
module pmnr_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] ID = 2'h1;  // Arbitrary identity value
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic atc = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [7:0] pin = 8'h00;
    logic [7:0] lev;
    logic [5:0] nen = 6'h00;
    logic [5:0] aen = 6'h00;
    logic [5:0] flags;
    logic nmi;
    pmnr_pkg::pmnr_port_shadow_type ps = 16'hb5c3;
    pmnr_pkg::pmnr_pic_shadow_type pc = 13'h1a5a;
    int bad_count = 0;
    int cmp_count = 0;
    logic [15:0] row_addr [4] = '{16'h9072, 16'hd072, 16'hd472, 16'hd473};
    logic [15:0] row_exp [4] = '{16'h0000, 16'hb5c3, {1'b1, ID, 13'h1a5a}, 16'h0000};
    pmnr_top #(.CHIP_IDENTITY_FIELD(ID)) pmnr_top_i (.clk_i(clk), .nrst_i(nrst), .io_addr_i(addr),
        .io_rd_i(rd), .io_wr_i(wr), .io_wdata_i(wdata), .io_rdata_o(rdata), .pm_in_i(pin),
        .nmi_enable_bits_i(nen), .attention_enable_bits_i(aen), .port_shadow_i(ps), .pic_shadow_i(pc),
        .activity_timeout_compare_i(atc), .nmi_cause_flags_o(flags), .pm_sense_levels_o(lev), .nmi_o(nmi));
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic access(input logic [15:0] a, input logic w);
        @(negedge clk);
        addr = a;
        wdata = (a == pmnr_pkg::NMI_CAUSE_STATUS_ADDR) ? 16'h00fc : 16'hffff;
        rd = !w;
        wr = w;
        @(negedge clk);
        rd = 1'b0;
        wr = 1'b0;
    endtask : access
    task automatic conclude;
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (20) @(negedge clk);
        chk({nmi, 1'b0, flags, lev}, 16'h0000);
        nrst = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            access(row_addr[k], 1'b1);
            access(row_addr[k], 1'b0);
            chk(rdata, row_exp[k]);
        end
        // Change with no enable
        pin = 8'h80;
        repeat (2) @(negedge clk);
        chk({10'h000, flags}, 16'h0000);
        nen = 6'h3f;
        @(negedge clk);
        // Input 7 falls, input 3 rises, input 0 live
        pin = 8'h09;
        repeat (2) @(negedge clk);
        chk({nmi, 5'h00, flags, lev[3:0]}, {1'b1, 5'h00, 6'h02, 4'h9});
        pin = 8'h89;
        access(16'h9072, 1'b0);
        chk(rdata, 16'h0088);
        // Both enables: needs both cleared
        aen = 6'h3f;
        @(negedge clk);
        nen = 6'h00;
        repeat (3) @(negedge clk);
        chk({10'h000, flags}, 16'h0022);
        aen = 6'h00;
        repeat (2) @(negedge clk);
        chk({nmi, 9'h000, flags}, 16'h0000);
        // Attention only latches status
        aen = 6'h02;
        pin = 8'h01;
        repeat (2) @(negedge clk);
        chk({nmi, 1'b0, flags, lev[3:0]}, 16'h0009);
        // Reset in mid-run
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        chk({nmi, 1'b0, flags, lev}, 16'h0000);
        chk(rdata, 16'h0000);
        // Release again: unlatched status live, latched status cleared
        atc = 1'b0;
        nrst = 1'b1;
        @(negedge clk);
        chk({nmi, 1'b0, flags, lev}, 16'h0001);
        access(16'hd472, 1'b0);
        chk(rdata, {1'b0, ID, 13'h1a5a});
        conclude();
    end
endmodule : pmnr_top_bench
